// [dac_pwr_consts.vh]
/*
  Constants for the channel power and fault supervisor: register offsets,
  field positions, reset values and timing counts.
  Assumes a 125 MHz system clock and a 32-bit classic Wishbone slave.
*/
`ifndef DAC_PWR_CONSTS_VH
`define DAC_PWR_CONSTS_VH

// ==========================================================================
// Register offsets (byte addresses)
`define OFS_POWER_CTRL     8'h08
`define OFS_CONTROL        8'h0c
`define OFS_DATA_WRITE     8'h10
`define OFS_SUPPLY_STAT    8'h14
`define OFS_SETTLE_STAT    8'h18

// ==========================================================================
// Register select pattern that names the power control register
`define REG_SEL_POWER      3'h2
`define REG_SEL_WIDTH      3

// ==========================================================================
// Power control register fields
`define PC_POWERUP_LSB     0
`define PC_THERMAL_BIT     5
`define PC_OVERCUR_LSB     7

// Control register fields
`define CTL_CLAMP_EN_BIT   0
`define CTL_THERMAL_EN_BIT 1

// Data write register: channel in bits 17:16, a word written with byte lane 2 selected marks channel valid
`define DW_CHAN_LSB        16

// ==========================================================================
// Reset values
`define RST_POWERUP        4'h0
`define RST_CLAMP_EN       1'b1
`define RST_THERMAL_EN     1'b0

// ==========================================================================
// Timing
`define CLK_FREQ_MHZ       125
`define POWERUP_TIME_NS    10000
`define POWERUP_CYCLES     ((`POWERUP_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define SETTLE_CNT_W       11

`endif

// [chan_settle_timer.v]
/*
  Power-up settle timer for one channel: counts the wait after the channel
  is powered up, before its output may be loaded.
  Assumes the power-up level comes from a flop in the same clock domain.
*/
`timescale 1ns/1ps
`include "dac_pwr_consts.vh"

module chan_settle_timer (
  input  wire clk_i,
  input  wire rst_n_i,
  input  wire powered_i,
  output reg  settled_o
);

  reg [`SETTLE_CNT_W-1:0] count;

  // Restarts whenever the channel drops out of power-up
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count     <= {`SETTLE_CNT_W{1'b0}};
      settled_o <= 1'b0;
    end else if (!powered_i) begin
      count     <= {`SETTLE_CNT_W{1'b0}};
      settled_o <= 1'b0;
    end else if (count == `POWERUP_CYCLES - 1) begin
      settled_o <= 1'b1;
    end else begin
      count <= count + {{(`SETTLE_CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule // chan_settle_timer

// [dac_channel_power_fault_control.v]
/*
  Channel power and fault supervisor for a four-channel voltage output
  converter: power-up output hold, per-channel power-down, overcurrent
  handling in clamp or auto power-down mode, and thermal shutdown.
  Assumes fault and supply inputs are already synchronous to clk_i and that
  software reaches the registers over classic Wishbone.
*/
// The implementer's own choices: the register addresses and register access over Wishbone.
// Behaviour
// - In power-up each output is grounded and isolated until supply good and a word lands.
// - Once that hold is met the ground clamp is released and the amplifier connected.
// - Each channel powers down on its own and all start powered down after reset.
// - A powered-down channel has its amplifier cut off and its pin clamped to ground.
// - The clamp-enable bit picks the overcurrent response: one limits, zero powers down.
// - In limit mode a short sets the channel overcurrent flag while current is limited.
// - In limit mode the overcurrent flag clears by itself when the short goes away.
// - In auto power-down mode a short powers down, clamps and isolates only that channel.
// - In auto power-down mode the shorted channel sets its flag and clears its power-up bit.
// - Thermal shutdown is off after reset and armed only by its control register enable bit.
// - When armed and the core overheats the device shuts down and sets the thermal flag.
// - A set power-up bit runs the channel and loading waits for the settle time.
// - With thermal enable set, overtemperature powers down all four channels and sets the read-only thermal flag.
// - The power control register is selected by the register-select pattern 010.
`timescale 1ns/1ps
`include "dac_pwr_consts.vh"

module dac_channel_power_fault_control (
  input  wire        clk_i,
  input  wire        rst_n_i,
  // Wishbone classic slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // Analog side status
  input  wire        supply_good_i,
  input  wire [3:0]  short_detect_i,
  input  wire        overtemp_i,
  // Analog side controls
  output reg  [3:0]  amp_output_gate_o,
  output reg  [3:0]  ground_clamp_gate_o,
  output reg  [3:0]  current_limit_o,
  output reg         thermal_shutdown_o,
  output wire [3:0]  load_allowed_o
);

  // ==========================================================================
  // Helpers

  // Register-select field of an offset, word index bits 4:2
  function [`REG_SEL_WIDTH-1:0] reg_sel;
    input [7:0] adr;
    begin
      reg_sel = adr[4:2];
    end
  endfunction

  // Byte lane merge of a 32-bit word
  function [31:0] merge_lanes;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  sel;
    integer      b;
    begin
      merge_lanes = old_val;
      for (b = 0; b < 4; b = b + 1) begin
        if (sel[b]) begin
          merge_lanes[b*8 +: 8] = new_val[b*8 +: 8];
        end
      end
    end
  endfunction

  // ==========================================================================
  // State

  reg  [3:0] channel_powerup_bit;
  reg  [3:0] overcurrent_flag;
  reg        thermal_flag;
  reg        clamp_enable;
  reg        thermal_enable;
  reg  [3:0] word_valid;
  reg  [3:0] short_q;
  reg        overtemp_q;
  wire [3:0] settled;

  reg  [3:0] next_powerup;
  reg  [3:0] next_overcurrent;
  reg        next_thermal;
  reg  [3:0] hold_release;
  reg  [3:0] run;

  wire        bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire        bus_wr   = bus_req & wb_we_i;
  wire        wr_power = bus_wr & (wb_adr_i == `OFS_POWER_CTRL)
                         & (reg_sel(wb_adr_i) == `REG_SEL_POWER);
  wire        wr_ctl   = bus_wr & (wb_adr_i == `OFS_CONTROL);
  wire        wr_data  = bus_wr & (wb_adr_i == `OFS_DATA_WRITE);
  wire [31:0] pc_word  = merge_lanes(32'h0000_0000, wb_dat_i, wb_sel_i);
  wire [31:0] ctl_word = merge_lanes({30'h0000_0000, thermal_enable, clamp_enable},
                                     wb_dat_i, wb_sel_i);
  wire [1:0]  data_ch  = wb_dat_i[`DW_CHAN_LSB +: 2];

  // ==========================================================================
  // Fault inputs are registered once on the clock
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      short_q    <= 4'h0;
      overtemp_q <= 1'b0;
    end else begin
      short_q    <= short_detect_i;
      overtemp_q <= overtemp_i;
    end
  end

  // ==========================================================================
  // Power and fault next state
  integer c;
  always @* begin
    next_powerup     = channel_powerup_bit;
    next_overcurrent = overcurrent_flag;
    next_thermal     = thermal_flag;
    if (wr_power && wb_sel_i[0]) begin
      next_powerup = pc_word[`PC_POWERUP_LSB +: 4];
    end
    for (c = 0; c < 4; c = c + 1) begin
      if (clamp_enable) begin
        // Flag follows the short directly, so it drops when the short goes
        next_overcurrent[c] = short_q[c] & channel_powerup_bit[c];
      end else if (short_q[c] && channel_powerup_bit[c]) begin
        // Fault on a channel already powered up beats a same-cycle software write of its bit
        next_overcurrent[c] = 1'b1;
        next_powerup[c]     = 1'b0;
      end else if (next_powerup[c] && !channel_powerup_bit[c]) begin
        // A fresh power-up starts with a clean flag
        next_overcurrent[c] = 1'b0;
      end
    end
    if (thermal_enable && overtemp_q) begin
      next_thermal = 1'b1;
      next_powerup = 4'h0;
    end else if (wr_power && wb_sel_i[0] && !overtemp_q) begin
      // Software re-arming the channels after cooling clears the flag
      next_thermal = 1'b0;
    end
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      channel_powerup_bit <= `RST_POWERUP;
      overcurrent_flag    <= 4'h0;
      thermal_flag        <= 1'b0;
    end else begin
      channel_powerup_bit <= next_powerup;
      overcurrent_flag    <= next_overcurrent;
      thermal_flag        <= next_thermal;
    end
  end

  // ==========================================================================
  // Control register
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clamp_enable   <= `RST_CLAMP_EN;
      thermal_enable <= `RST_THERMAL_EN;
    end else if (wr_ctl) begin
      clamp_enable   <= ctl_word[`CTL_CLAMP_EN_BIT];
      thermal_enable <= ctl_word[`CTL_THERMAL_EN_BIT];
    end
  end

  // ==========================================================================
  // Power-up hold: a channel stays held until a word lands while supplies
  // are good; a supply drop re-arms the hold for every channel.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_valid <= 4'h0;
    end else if (!supply_good_i) begin
      word_valid <= 4'h0;
    end else if (wr_data && wb_sel_i[2]) begin
      word_valid[data_ch] <= 1'b1;
    end
  end

  // ==========================================================================
  // Settle timers
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_settle
      chan_settle_timer u_settle (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .powered_i (channel_powerup_bit[g]),
        .settled_o (settled[g])
      );
    end
  endgenerate

  assign load_allowed_o = settled & word_valid & {4{supply_good_i}};

  // ==========================================================================
  // Output gates
  always @* begin
    hold_release = word_valid & {4{supply_good_i}};
    run          = hold_release & channel_powerup_bit;
  end

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      amp_output_gate_o   <= 4'h0;
      ground_clamp_gate_o <= 4'hf;
      current_limit_o     <= 4'h0;
      thermal_shutdown_o  <= 1'b0;
    end else begin
      amp_output_gate_o   <= run;
      ground_clamp_gate_o <= ~run;
      current_limit_o     <= {4{clamp_enable}} & short_q & channel_powerup_bit;
      thermal_shutdown_o  <= thermal_flag;
    end
  end

  // ==========================================================================
  // Wishbone slave: registered ack one cycle after the request; unmapped reads return zero
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= 32'h0000_0000;
      if (bus_req && !wb_we_i) begin
        case (wb_adr_i)
          `OFS_POWER_CTRL: begin
            wb_dat_o <= {21'h000000, overcurrent_flag, 1'b0, thermal_flag,
                         1'b0, channel_powerup_bit};
          end
          `OFS_CONTROL: begin
            wb_dat_o <= {30'h00000000, thermal_enable, clamp_enable};
          end
          `OFS_SUPPLY_STAT: begin
            wb_dat_o <= {27'h0000000, word_valid, supply_good_i};
          end
          `OFS_SETTLE_STAT: begin
            wb_dat_o <= {28'h0000000, load_allowed_o};
          end
          default: begin
            wb_dat_o <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

endmodule // dac_channel_power_fault_control

// [dac_pwr_properties.sv]
/* Port assertions for the channel power and fault supervisor.
   Assumes one clock domain and the active-low asynchronous reset. */
`timescale 1ns/1ps
module dac_pwr_properties (
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        supply_good_i,
  input wire logic [3:0]  short_detect_i,
  input wire logic        overtemp_i,
  input wire logic [3:0]  amp_output_gate_o,
  input wire logic [3:0]  ground_clamp_gate_o,
  input wire logic [3:0]  current_limit_o,
  input wire logic        thermal_shutdown_o,
  input wire logic [3:0]  load_allowed_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================
  // Helper: cycles channel 0 has been connected, saturating
  logic [10:0] on_cnt;
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) on_cnt <= 11'h000;
    else if (!amp_output_gate_o[0]) on_cnt <= 11'h000;
    else if (on_cnt != 11'h7ff) on_cnt <= on_cnt + 11'h001;
  // ==========================================
  // Assertions
  property p_clamp_inverse; ground_clamp_gate_o == ~amp_output_gate_o; endproperty
  a_clamp_inverse: assert property (p_clamp_inverse)
    else $error("clamp gate not inverse of amp gate");
  property p_supply_hold; !supply_good_i [*3] |-> amp_output_gate_o == 4'h0; endproperty
  a_supply_hold: assert property (p_supply_hold)
    else $error("amp connected without supply");
  property p_short_response;
    (short_detect_i & $past(short_detect_i) & $past(short_detect_i, 2)
     & $past(short_detect_i, 3) & amp_output_gate_o & ~current_limit_o) == 4'h0;
  endproperty
  a_short_response: assert property (p_short_response)
    else $error("short neither limited nor powered down");
  property p_limit_clear; (short_detect_i == 4'h0) [*3] |-> current_limit_o == 4'h0; endproperty
  a_limit_clear: assert property (p_limit_clear)
    else $error("limit held without short");
  property p_thermal_cause;
    $rose(thermal_shutdown_o) |-> $past(overtemp_i) || $past(overtemp_i, 3);
  endproperty
  a_thermal_cause: assert property (p_thermal_cause)
    else $error("thermal flag without overtemperature");
  property p_thermal_off; $rose(thermal_shutdown_o) |-> ##[0:2] amp_output_gate_o == 4'h0;
  endproperty
  a_thermal_off: assert property (p_thermal_off)
    else $error("channels alive after thermal event");
  property p_load_gate; (load_allowed_o & ~amp_output_gate_o) == 4'h0; endproperty
  a_load_gate: assert property (p_load_gate)
    else $error("load allowed on powered-down channel");
  property p_load_settle; $rose(load_allowed_o[0]) |-> on_cnt >= 11'h4d8; endproperty
  a_load_settle: assert property (p_load_settle)
    else $error("load allowed before settle time");
  property p_ack_once; (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once)
    else $error("ack not a single cycle after request");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data outside ack");
endmodule // dac_pwr_properties

// [dac_channel_power_fault_control_test.sv]
/* Self-checking bench for the power and fault supervisor.
   Drives Wishbone and the analog status inputs itself; no partner model. */
`timescale 1ns/1ps
`include "dac_pwr_consts.vh"
module dac_channel_power_fault_control_test;
  logic        clk_i = 1'b0, rst_n_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0, supply_good_i = 1'b0, overtemp_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0, short_detect_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        wb_ack_o, thermal_shutdown_o;
  logic [3:0]  amp_output_gate_o, ground_clamp_gate_o, current_limit_o, load_allowed_o;
  int          error_cnt = 0, n_checks = 0, ch, k;
  always #4 clk_i = ~clk_i;
  dac_channel_power_fault_control i_dac_channel_power_fault_control (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .supply_good_i(supply_good_i),
    .short_detect_i(short_detect_i), .overtemp_i(overtemp_i),
    .amp_output_gate_o(amp_output_gate_o), .ground_clamp_gate_o(ground_clamp_gate_o),
    .current_limit_o(current_limit_o), .thermal_shutdown_o(thermal_shutdown_o),
    .load_allowed_o(load_allowed_o));
  // ==========================================
  // Reporting and bus tasks
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  // Request held until ack is sampled, then released
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++) @(posedge clk_i);
    if (k == 20) begin
      error_cnt++;
      $display("[FAIL] %0t no ack", $time);
      end_sim();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  function automatic logic [31:0] exp_pc(logic [3:0] pu, logic th, logic [3:0] oc);
    return {21'h0, oc, 1'b0, th, 1'b0, pu};
  endfunction
  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(26738));
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    supply_good_i <= 1'b1;
    @(posedge clk_i);
    check(amp_output_gate_o, 4'h0, "amp at reset");
    check(ground_clamp_gate_o, 4'hf, "clamp at reset");
    wb(0, `OFS_POWER_CTRL, 0); check(rd, exp_pc(4'h0, 0, 4'h0), "pc reset");
    wb(0, `OFS_CONTROL, 0); check(rd, 32'h1, "ctl reset");
    wb(0, 8'h04, 0); check(rd, 32'h0, "unmapped");
    wb(1, `OFS_POWER_CTRL, 32'hf);
    repeat (4) @(posedge clk_i);
    check(amp_output_gate_o, 4'h0, "no word yet");
    for (ch = 0; ch < 4; ch++) begin
      wb(1, `OFS_DATA_WRITE, {14'h0, ch[1:0], 16'($urandom)});
      repeat (4) @(posedge clk_i);
      check(amp_output_gate_o, 4'hf >> (3 - ch), "word released");
    end
    ch = $urandom_range(3, 0);
    short_detect_i <= 4'h1 << ch;
    repeat (4) @(posedge clk_i);
    check(current_limit_o, 4'h1 << ch, "limit");
    wb(0, `OFS_POWER_CTRL, 0); check(rd, exp_pc(4'hf, 0, 4'h1 << ch), "oc set");
    short_detect_i <= 4'h0;
    repeat (4) @(posedge clk_i);
    wb(0, `OFS_POWER_CTRL, 0); check(rd, exp_pc(4'hf, 0, 4'h0), "oc clear");
    wb(1, `OFS_CONTROL, 32'h0);
    short_detect_i <= 4'h1 << ch;
    repeat (4) @(posedge clk_i);
    check(amp_output_gate_o, 4'hf & ~(4'h1 << ch), "auto off");
    wb(0, `OFS_POWER_CTRL, 0);
    check(rd, exp_pc(4'hf & ~(4'h1 << ch), 0, 4'h1 << ch), "auto flags");
    short_detect_i <= 4'h0;
    repeat (3) @(posedge clk_i);
    wb(1, `OFS_POWER_CTRL, 32'hf);
    for (k = 0; k < 1400 && load_allowed_o[ch] !== 1'b1; k++) @(posedge clk_i);
    check(k >= 1240 && k <= 1256, 1, "settle time");
    check(amp_output_gate_o, 4'hf, "restored");
    overtemp_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    check(thermal_shutdown_o, 0, "thermal disarmed");
    wb(1, `OFS_CONTROL, 32'h3);
    repeat (4) @(posedge clk_i);
    check(amp_output_gate_o, 4'h0, "thermal off");
    check(thermal_shutdown_o, 1, "thermal out");
    wb(0, `OFS_POWER_CTRL, 0); check(rd & 32'h20, 32'h20, "thermal flag");
    overtemp_i <= 1'b0;
    supply_good_i <= 1'b0;
    wb(1, `OFS_POWER_CTRL, 32'hf);
    repeat (4) @(posedge clk_i);
    check(amp_output_gate_o, 4'h0, "supply low");
    end_sim();
  end
endmodule // dac_channel_power_fault_control_test

bind dac_channel_power_fault_control dac_pwr_properties i_dac_pwr_properties (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .supply_good_i(supply_good_i),
  .short_detect_i(short_detect_i), .overtemp_i(overtemp_i),
  .amp_output_gate_o(amp_output_gate_o), .ground_clamp_gate_o(ground_clamp_gate_o),
  .current_limit_o(current_limit_o), .thermal_shutdown_o(thermal_shutdown_o),
  .load_allowed_o(load_allowed_o));
